// *** dpwm_pkg.sv ***
/*
  dpwm_pkg: register map, control field layout, reset values and timing
  constants of the dual pwm timer.
  Assumes an 8-bit register port with a 4-bit address.
*/
package dpwm_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 10;
  localparam int NCH = 2;
  localparam int PRE_W = 6;
  // register addresses
  localparam logic [3:0] ADDR_PER1_LO = 4'h0;
  localparam logic [3:0] ADDR_PER1_HI = 4'h1;
  localparam logic [3:0] ADDR_DUTY1_LO = 4'h2;
  localparam logic [3:0] ADDR_DUTY1_HI = 4'h3;
  localparam logic [3:0] ADDR_CTRL = 4'h5;
  localparam logic [3:0] ADDR_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_MASK = 4'h7;
  localparam logic [3:0] ADDR_PER2_LO = 4'h8;
  localparam logic [3:0] ADDR_PER2_HI = 4'h9;
  localparam logic [3:0] ADDR_DUTY2_LO = 4'hA;
  localparam logic [3:0] ADDR_DUTY2_HI = 4'hB;
  localparam logic [3:0] ADDR_CNT1_LO = 4'hC;
  localparam logic [3:0] ADDR_CNT1_HI = 4'hD;
  localparam logic [3:0] ADDR_CNT2_LO = 4'hE;
  localparam logic [3:0] ADDR_CNT2_HI = 4'hF;
  // control register fields
  localparam int CTRL_PRE_LSB = 0;
  localparam int CTRL_CEN_LSB = 4;
  localparam int CTRL_OEN_LSB = 6;
  // flag and mask bit of each channel
  localparam int IRQ_BIT_ONE = 4;
  localparam int IRQ_BIT_TWO = 7;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [9:0] PER_RST = 10'h000;
  localparam logic [9:0] DUTY_RST = 10'h000;
  // prescale ratio minus one, per select code
  localparam logic [5:0] PRE_DIV2_M1 = 6'h01;
  localparam logic [5:0] PRE_DIV8_M1 = 6'h07;
  localparam logic [5:0] PRE_DIV32_M1 = 6'h1F;
  localparam logic [5:0] PRE_DIV64_M1 = 6'h3F;
  // sub-steps of one counter increment
  localparam logic [1:0] QTR_LAST = 2'h3;
endpackage : dpwm_pkg

// *** dpwm_top.sv ***
/*
  dpwm_top: two 10-bit pwm channels with prescaler, period, duty shadow,
  period flags with mask, behind a plain 8-bit register port.
  Assumes strobes synchronous to clk, one cycle long, never both at once.
*/
// Our own choice: strobed register access.
// What this block does
// - two independent pwm outputs, ten-bit period and duty each
// - each channel has ten-bit up-counter fed through own prescaler
// - counter enable bits 4 and 5 stop their counters when clear
// - counter equal to period clears to zero on next increment
// - period match drives output high unless duty is zero
// - duty copied into duty latch only at period-match clear
// - counter with quarter step reaching latched duty drives output low for the period
// - duty writes accepted anytime, effective only at next match
// - period match sets channel period flag
// - period lasts (period+1) times four clocks times prescale ratio
// - high time lasts duty clocks times prescale ratio
// - prescale select gives 1:2, 1:8, 1:32, 1:64, cleared by reset
// - control bits: oe2, oe1, ce2, ce1, pre2[1:0], pre1[1:0]
// - counters cleared by every reset
// - period flag reaches interrupt only with mask bit set
`timescale 1ns/1ps
module dpwm_top #(
  parameter int CNT_W = dpwm_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic pulse_output_one,
  output logic pulse_output_two,
  output logic period_irq_one,
  output logic period_irq_two
);
  localparam int NCH = dpwm_pkg::NCH;

  // only the documented counter width is served
  if (CNT_W != 10) begin : g_bad_width
    $error("dpwm_top: CNT_W must be 10");
  end

  // prescale select code to ratio minus one
  function automatic logic [5:0] pre_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0: pre_limit = dpwm_pkg::PRE_DIV2_M1;
      2'h1: pre_limit = dpwm_pkg::PRE_DIV8_M1;
      2'h2: pre_limit = dpwm_pkg::PRE_DIV32_M1;
      2'h3: pre_limit = dpwm_pkg::PRE_DIV64_M1;
    endcase
  endfunction : pre_limit

  // flag and mask bit position of a channel
  function automatic int irq_bit(input int c);
    irq_bit = (c == 0) ? dpwm_pkg::IRQ_BIT_ONE : dpwm_pkg::IRQ_BIT_TWO;
  endfunction : irq_bit

  logic [7:0] ctrl_q;
  logic [7:0] mask_q;
  logic [NCH-1:0] flag_q;
  logic [NCH-1:0] flag_d;
  logic [NCH-1:0][9:0] per_q;
  logic [NCH-1:0][9:0] duty_q;
  logic [NCH-1:0][9:0] dlat_q;
  logic [NCH-1:0][9:0] dlat_d;
  logic [NCH-1:0][9:0] cnt_q;
  logic [NCH-1:0][9:0] cnt_d;
  logic [NCH-1:0][5:0] pre_q;
  logic [NCH-1:0][5:0] pre_d;
  logic [NCH-1:0][1:0] qtr_q;
  logic [NCH-1:0][1:0] qtr_d;
  logic [NCH-1:0] lvl_q;
  logic [NCH-1:0] lvl_d;
  logic [NCH-1:0] pin_q;
  logic [NCH-1:0] irq_q;
  logic [NCH-1:0] run;
  logic [NCH-1:0] oen;
  logic [NCH-1:0] qtick;
  logic [NCH-1:0] inc;
  logic [NCH-1:0] match;
  logic [NCH-1:0][11:0] fine_next;
  logic [7:0] rd_mux;
  logic [7:0] rd_q;

  // register write decode
  wire wr_ctrl = wr_en && (addr == dpwm_pkg::ADDR_CTRL);
  wire wr_flags = wr_en && (addr == dpwm_pkg::ADDR_FLAGS);
  wire wr_mask = wr_en && (addr == dpwm_pkg::ADDR_MASK);
  wire [NCH-1:0] wr_per_lo = {wr_en && addr == dpwm_pkg::ADDR_PER2_LO,
                              wr_en && addr == dpwm_pkg::ADDR_PER1_LO};
  wire [NCH-1:0] wr_per_hi = {wr_en && addr == dpwm_pkg::ADDR_PER2_HI,
                              wr_en && addr == dpwm_pkg::ADDR_PER1_HI};
  wire [NCH-1:0] wr_duty_lo = {wr_en && addr == dpwm_pkg::ADDR_DUTY2_LO,
                               wr_en && addr == dpwm_pkg::ADDR_DUTY1_LO};
  wire [NCH-1:0] wr_duty_hi = {wr_en && addr == dpwm_pkg::ADDR_DUTY2_HI,
                               wr_en && addr == dpwm_pkg::ADDR_DUTY1_HI};

  // control fields per channel
  assign run = ctrl_q[dpwm_pkg::CTRL_CEN_LSB +: NCH];
  assign oen = ctrl_q[dpwm_pkg::CTRL_OEN_LSB +: NCH];

  // channel time base: prescaler, quarter step, counter, duty level
  // the quarter step gives the factor four on the period while the
  // duty compare sees every prescaler tick, so high time is duty*ratio
  // limitation: a period lowered below the running count lets it wrap at 1024,
  // and a ratio lowered mid-count lets the prescaler run round through 63
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      qtick[c] = run[c] && (pre_q[c] == pre_limit(ctrl_q[2*c +: 2]));
      inc[c] = qtick[c] && (qtr_q[c] == dpwm_pkg::QTR_LAST);
      match[c] = inc[c] && (cnt_q[c] == per_q[c]);
      if (!run[c]) begin
        pre_d[c] = pre_q[c];
      end else if (qtick[c]) begin
        pre_d[c] = 6'h00;
      end else begin
        pre_d[c] = pre_q[c] + 6'h01;
      end
      qtr_d[c] = qtick[c] ? qtr_q[c] + 2'h1 : qtr_q[c];
      if (match[c]) begin
        cnt_d[c] = 10'h000;
      end else if (inc[c]) begin
        cnt_d[c] = cnt_q[c] + 10'h001;
      end else begin
        cnt_d[c] = cnt_q[c];
      end
      dlat_d[c] = match[c] ? duty_q[c] : dlat_q[c];
      fine_next[c] = {cnt_d[c], qtr_d[c]};
      if (match[c]) begin
        lvl_d[c] = (duty_q[c] != 10'h000);
      end else if (qtick[c] && fine_next[c] == {2'h0, dlat_q[c]}) begin
        lvl_d[c] = 1'b0;
      end else begin
        lvl_d[c] = lvl_q[c];
      end
      // set wins over a write-one clear in the same cycle
      flag_d[c] = match[c] | (flag_q[c] & ~(wr_flags & wr_data[irq_bit(c)]));
    end
  end

  // read mux; unmapped address reads zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      dpwm_pkg::ADDR_PER1_LO: rd_mux = per_q[0][7:0];
      dpwm_pkg::ADDR_PER1_HI: rd_mux = {6'h00, per_q[0][9:8]};
      dpwm_pkg::ADDR_DUTY1_LO: rd_mux = duty_q[0][7:0];
      dpwm_pkg::ADDR_DUTY1_HI: rd_mux = {6'h00, duty_q[0][9:8]};
      dpwm_pkg::ADDR_CTRL: rd_mux = ctrl_q;
      dpwm_pkg::ADDR_FLAGS: rd_mux = {flag_q[1], 2'h0, flag_q[0], 4'h0};
      dpwm_pkg::ADDR_MASK: rd_mux = mask_q;
      dpwm_pkg::ADDR_PER2_LO: rd_mux = per_q[1][7:0];
      dpwm_pkg::ADDR_PER2_HI: rd_mux = {6'h00, per_q[1][9:8]};
      dpwm_pkg::ADDR_DUTY2_LO: rd_mux = duty_q[1][7:0];
      dpwm_pkg::ADDR_DUTY2_HI: rd_mux = {6'h00, duty_q[1][9:8]};
      dpwm_pkg::ADDR_CNT1_LO: rd_mux = cnt_q[0][7:0];
      dpwm_pkg::ADDR_CNT1_HI: rd_mux = {6'h00, cnt_q[0][9:8]};
      dpwm_pkg::ADDR_CNT2_LO: rd_mux = cnt_q[1][7:0];
      dpwm_pkg::ADDR_CNT2_HI: rd_mux = {6'h00, cnt_q[1][9:8]};
      default: rd_mux = 8'h00;
    endcase
  end

  // software registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= dpwm_pkg::CTRL_RST;
      mask_q <= dpwm_pkg::MASK_RST;
      per_q <= '0;
      duty_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= wr_data;
      if (wr_mask) mask_q <= wr_data;
      for (int c = 0; c < NCH; c++) begin
        if (wr_per_lo[c]) per_q[c][7:0] <= wr_data;
        if (wr_per_hi[c]) per_q[c][9:8] <= wr_data[1:0];
        if (wr_duty_lo[c]) duty_q[c][7:0] <= wr_data;
        if (wr_duty_hi[c]) duty_q[c][9:8] <= wr_data[1:0];
      end
    end
  end

  // channel state; every reset clears prescaler and counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= '0;
      qtr_q <= '0;
      cnt_q <= '0;
      dlat_q <= '0;
      lvl_q <= '0;
      flag_q <= '0;
    end else begin
      pre_q <= pre_d;
      qtr_q <= qtr_d;
      cnt_q <= cnt_d;
      dlat_q <= dlat_d;
      lvl_q <= lvl_d;
      flag_q <= flag_d;
    end
  end

  // registered pins, interrupts and read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_q <= '0;
      irq_q <= '0;
      rd_q <= 8'h00;
    end else begin
      pin_q <= lvl_d & oen;
      // next-state flag, so the line rises in the same cycle as the flag
      for (int c = 0; c < NCH; c++) begin
        irq_q[c] <= flag_d[c] & mask_q[irq_bit(c)];
      end
      rd_q <= rd_en ? rd_mux : 8'h00;
    end
  end

  assign pulse_output_one = pin_q[0];
  assign pulse_output_two = pin_q[1];
  assign period_irq_one = irq_q[0];
  assign period_irq_two = irq_q[1];
  assign rd_data = rd_q;

  // per-channel checks
  for (genvar g = 0; g < NCH; g++) begin : g_chk
    chk_match_clears: assert property (@(posedge clk) disable iff (!rstn)
      match[g] |=> cnt_q[g] == 10'h000)
      else $error("counter not cleared after period match");
    chk_flag_sets: assert property (@(posedge clk) disable iff (!rstn)
      match[g] |=> flag_q[g])
      else $error("period flag not set on match");
    chk_latch_hold: assert property (@(posedge clk) disable iff (!rstn)
      !match[g] |=> $stable(dlat_q[g]))
      else $error("duty latch changed outside period match");
    chk_stop_hold: assert property (@(posedge clk) disable iff (!rstn)
      !run[g] |=> $stable(cnt_q[g]) && $stable(pre_q[g]))
      else $error("stopped counter moved");
    chk_zero_duty: assert property (@(posedge clk) disable iff (!rstn)
      match[g] && duty_q[g] == 10'h000 |=> !lvl_q[g] ##1 !pin_q[g])
      else $error("output rose with zero duty");
    chk_high_start: assert property (@(posedge clk) disable iff (!rstn)
      match[g] && duty_q[g] != 10'h000 |=> lvl_q[g])
      else $error("output not high after period match");
    chk_duty_low: assert property (@(posedge clk) disable iff (!rstn)
      qtick[g] && !match[g] && fine_next[g] == {2'h0, dlat_q[g]} |=> !lvl_q[g])
      else $error("output not low at duty compare");
    chk_tick_only: assert property (@(posedge clk) disable iff (!rstn)
      !inc[g] |=> $stable(cnt_q[g]))
      else $error("counter moved without increment tick");
    chk_pin_gate: assert property (@(posedge clk) disable iff (!rstn)
      !oen[g] |=> !pin_q[g])
      else $error("pin driven with output enable clear");
    // interrupt path: the mask gates, a standing flag keeps the line up
    chk_irq_mask: assert property (@(posedge clk) disable iff (!rstn)
      !mask_q[irq_bit(g)] |=> !irq_q[g])
      else $error("interrupt raised with mask bit clear");
    chk_irq_follow: assert property (@(posedge clk) disable iff (!rstn)
      flag_q[g] && mask_q[irq_bit(g)] && !wr_flags |=> irq_q[g])
      else $error("interrupt dropped while flag and mask stand");
    chk_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
      wr_flags && wr_data[irq_bit(g)] && !match[g] |=> !flag_q[g])
      else $error("flag not cleared by a write of one");
    chk_flag_keep: assert property (@(posedge clk) disable iff (!rstn)
      !flag_q[g] && !match[g] |=> !flag_q[g])
      else $error("flag set without a period match");
    // duty path: the latch takes the written duty, a low level holds
    chk_latch_take: assert property (@(posedge clk) disable iff (!rstn)
      match[g] |=> dlat_q[g] == $past(duty_q[g]))
      else $error("duty latch missed the written duty");
    chk_low_hold: assert property (@(posedge clk) disable iff (!rstn)
      !lvl_q[g] && !match[g] |=> !lvl_q[g])
      else $error("output rose away from a period match");
    chk_pin_follow: assert property (@(posedge clk) disable iff (!rstn)
      oen[g] |=> pin_q[g] == lvl_q[g])
      else $error("enabled pin differs from channel level");
    // time base: prescaler restarts on a tick, four ticks per step
    chk_tick_restart: assert property (@(posedge clk) disable iff (!rstn)
      qtick[g] |=> pre_q[g] == 6'h00)
      else $error("prescaler not restarted after tick");
    chk_step_wrap: assert property (@(posedge clk) disable iff (!rstn)
      inc[g] |=> qtr_q[g] == 2'h0)
      else $error("quarter step not wrapped at counter increment");
  end

  // read data only in the cycle after a read strobe
  chk_read_slot: assert property (@(posedge clk) disable iff (!rstn)
    !rd_en |=> rd_data == 8'h00)
    else $error("read data outside read slot");

  // control writes land at once and read back in the next cycle
  chk_ctrl_take: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctrl |=> ctrl_q == $past(wr_data))
    else $error("control register missed a write");
  chk_ctrl_read: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && addr == dpwm_pkg::ADDR_CTRL |=> rd_data == $past(ctrl_q))
    else $error("control read returned a stale value");
endmodule : dpwm_top

// *** tb_dual_pwm_timer.sv ***
/*
  tb_dual_pwm_timer: self-checking bench for dpwm_top; reads are queued
  as notes and compared when read data stands, pulses are timed at pins.
  Assumes dpwm_pkg is compiled first and a 20 MHz clock.
*/
`timescale 1ns/1ps
module tb_dual_pwm_timer;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  wire [7:0] rd_data;
  wire [1:0] pin;
  wire [1:0] irq;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [15:0] h, p, hb;
  logic [9:0] per, duty;
  int n_fail = 0;
  int num_checks = 0;
  int rt[4] = '{2, 8, 32, 64};

  dpwm_top i_dpwm_top (.clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pulse_output_one(pin[0]),
    .pulse_output_two(pin[1]), .period_irq_one(irq[0]), .period_irq_two(irq[1]));

  // 50 ns period
  always #25 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // read data stands one cycle after the strobe; oldest note is popped
  always @(posedge clk) begin
    if (rd_pend && exp_q.size() > 0) begin
      chk({8'h00, rd_data}, {8'h00, exp_q.pop_front()});
    end
    rd_pend = rd_en;
  end

  // strobes last one cycle; the leading edge wait keeps them apart
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd

  task automatic wr10(input logic [3:0] a, input logic [9:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, {6'h00, v[9:8]});
  endtask : wr10

  // async reset mid-run also restarts the counters from zero
  task automatic rst();
    // one edge first, so a read just issued is compared before reset
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
  endtask : rst

  // high time and period from one rising edge to the next, bounded
  task automatic meas(input int ch, output logic [15:0] hi, output logic [15:0] pd);
    int g;
    g = 0;
    while (pin[ch] !== 1'b1 && g < 20000) begin
      @(posedge clk);
      g++;
    end
    hi = 16'h0000;
    do begin
      @(posedge clk);
      hi++;
    end while (pin[ch] === 1'b1 && hi < 16'd20000);
    pd = hi;
    do begin
      @(posedge clk);
      pd++;
    end while (pin[ch] !== 1'b1 && pd < 16'd20000);
    if (g >= 20000 || pd >= 16'd20000) begin
      n_fail++;
      $display("CHECK FAILED at %0t: pulse wait timed out", $time);
      final_report();
    end
  endtask : meas

  // main sequence
  initial begin
    void'($urandom(32'hafe8e697));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // every place reads zero after reset, unmapped one included
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
    hb = 16'($urandom_range(255));
    wr(dpwm_pkg::ADDR_CTRL, hb[7:0]);
    rd(dpwm_pkg::ADDR_CTRL, hb[7:0]);
    // every prescale code on both channels, random period and duty
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 4; c++) begin
        rst();
        per = 10'($urandom_range(3));
        duty = 10'($urandom_range(4 * per + 3, 1));
        wr10(4'(ch * 8), per);
        wr10(4'(ch * 8 + 2), duty);
        wr(dpwm_pkg::ADDR_CTRL, ch == 1 ? 8'hA0 | 8'(c << 2) : 8'h50 | 8'(c));
        meas(ch, h, p);
        meas(ch, h, p);
        chk(h, 16'(duty * rt[c]));
        chk(p, 16'((per + 1) * 4 * rt[c]));
      end
    end
    rd(dpwm_pkg::ADDR_FLAGS, 8'h80);
    chk({15'h0000, irq[1]}, 16'h0000);
    wr(dpwm_pkg::ADDR_MASK, 8'h80);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq[1]}, 16'h0001);
    wr(dpwm_pkg::ADDR_CTRL, 8'h00);
    wr(dpwm_pkg::ADDR_FLAGS, 8'hFF);
    repeat (2) @(posedge clk);
    chk({14'h0000, irq}, 16'h0000);
    repeat (3000) @(posedge clk);
    rd(dpwm_pkg::ADDR_FLAGS, 8'h00);
    // duty rewritten mid-pulse must wait for the next period match
    rst();
    wr10(dpwm_pkg::ADDR_PER1_LO, 10'd15);
    wr10(dpwm_pkg::ADDR_DUTY1_LO, 10'd20);
    wr(dpwm_pkg::ADDR_CTRL, 8'h50);
    meas(0, h, p);
    fork
      meas(0, h, p);
      begin
        repeat (3) @(posedge clk);
        wr10(dpwm_pkg::ADDR_DUTY1_LO, 10'd2);
      end
    join
    chk(h, 16'd40);
    meas(0, h, p);
    chk(h, 16'd4);
    chk(p, 16'd128);
    // zero duty keeps the pin low across whole periods
    wr10(dpwm_pkg::ADDR_DUTY1_LO, 10'd0);
    repeat (300) @(posedge clk);
    hb = 16'h0000;
    repeat (256) begin
      @(posedge clk);
      if (pin[0] !== 1'b0) hb++;
    end
    chk(hb, 16'h0000);
    // counter as a plain timer: output enable low, flag and interrupt still work
    wr(dpwm_pkg::ADDR_CTRL, 8'h10);
    wr10(dpwm_pkg::ADDR_DUTY1_LO, 10'd2);
    wr(dpwm_pkg::ADDR_FLAGS, 8'h10);
    hb = 16'h0000;
    repeat (300) begin
      @(posedge clk);
      if (pin[0] !== 1'b0) hb++;
    end
    chk(hb, 16'h0000);
    rd(dpwm_pkg::ADDR_FLAGS, 8'h10);
    wr(dpwm_pkg::ADDR_MASK, 8'h10);
    repeat (2) @(posedge clk);
    chk({14'h0000, irq}, 16'h0001);
    // a reset in mid-count returns the running counter to zero
    rst();
    rd(dpwm_pkg::ADDR_CNT1_LO, 8'h00);
    rd(dpwm_pkg::ADDR_CNT1_HI, 8'h00);
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule : tb_dual_pwm_timer
